// [hdl/rcpa_defines.svh]
`ifndef RCPA_DEFINES_SVH
`define RCPA_DEFINES_SVH
`define RCPA_ADDR_TIMECODE   9'h104
`define RCPA_ADDR_IDENT      9'h105
`define RCPA_ADDR_GENERAL    9'h106
`define RCPA_ADDR_KEY        9'h109
`define RCPA_KEY_RESET       8'h20
`define RCPA_KEY_MSB         7
`define RCPA_RST2OP_NS       20
`define RCPA_CLK_NS          20
`define RCPA_RST2OP_CYC      ((`RCPA_RST2OP_NS) / (`RCPA_CLK_NS))
`define RCPA_LOCK_US         20
`define RCPA_LOCK_CYC        ((`RCPA_LOCK_US * 1000) / (`RCPA_CLK_NS))
`define RCPA_ST_OK           2'h0
`define RCPA_ST_NACK         2'h1
`define RCPA_ST_RDONLY       2'h2
`define RCPA_ST_KEYBAD       2'h3
`endif

// [hdl/rcpa_pkg.sv]
package rcpa_pkg;
  typedef logic [1:0] rcpa_status_t;
  typedef enum logic [1:0] {RCPA_REG_NONE, RCPA_REG_RW, RCPA_REG_RO} rcpa_kind_e;
endpackage : rcpa_pkg

// [hdl/rcpa_config_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rcpa_defines.svh"
module rcpa_config_port #(
  parameter int unsigned LOCK_CYCLES = `RCPA_LOCK_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                cmd_valid_i,
  input  wire logic                cmd_empty_i,
  input  wire logic                cmd_write_i,
  input  wire logic [8:0]          cmd_addr_i,
  input  wire logic [31:0]         cmd_wdata_i,
  input  wire logic                cmd_key_req_i,
  input  wire logic [7:0]          cmd_key_i,
  input  wire logic [7:0]          time_code_i,
  input  wire logic [31:0]         ident_i,
  output logic                     ready_o,
  output logic                     reply_valid_o,
  output rcpa_pkg::rcpa_status_t   reply_status_o,
  output logic [31:0]              reply_rdata_o,
  output logic [`RCPA_KEY_MSB:0]   security_match_key_o,
  output logic                     tx_lock_o
);
  logic [7:0]  key_q, key_d;
  logic [31:0] gp_q, gp_d;
  logic        rv_q, rv_d;
  logic [1:0]  rs_q, rs_d;
  logic [31:0] rd_q, rd_d;
  logic [15:0] lock_q, lock_d;
  rcpa_pkg::rcpa_kind_e kind;

  function automatic rcpa_pkg::rcpa_kind_e rcpa_decode(input logic [8:0] a);
    unique case (a)
      `RCPA_ADDR_KEY, `RCPA_ADDR_GENERAL:   rcpa_decode = rcpa_pkg::RCPA_REG_RW;
      `RCPA_ADDR_TIMECODE, `RCPA_ADDR_IDENT: rcpa_decode = rcpa_pkg::RCPA_REG_RO;
      default:                              rcpa_decode = rcpa_pkg::RCPA_REG_NONE;
    endcase
  endfunction : rcpa_decode

  // Synchronous reset with no settling states: ready_o is tied high, even while reset is held
  assign ready_o = 1'b1;
  assign kind    = rcpa_decode(cmd_addr_i);

  always_comb begin
    key_d  = key_q;
    gp_d   = gp_q;
    rv_d   = 1'b0;
    rs_d   = `RCPA_ST_OK;
    rd_d   = rd_q;
    lock_d = (lock_q < LOCK_CYCLES[15:0]) ? lock_q + 16'h0001 : lock_q;
    if (cmd_valid_i && !cmd_empty_i) begin
      rv_d = 1'b1;
      rd_d = 32'h0000_0000;
      if (cmd_key_req_i && cmd_key_i != key_q) begin
        rs_d = `RCPA_ST_KEYBAD;
      end else if (kind == rcpa_pkg::RCPA_REG_NONE) begin
        rs_d = `RCPA_ST_NACK;
      end else if (cmd_write_i && kind == rcpa_pkg::RCPA_REG_RO) begin
        rs_d = `RCPA_ST_RDONLY;
      end else if (cmd_write_i) begin
        if (cmd_addr_i == `RCPA_ADDR_KEY) key_d = cmd_wdata_i[7:0];
        else gp_d = cmd_wdata_i;
      end else begin
        unique case (cmd_addr_i)
          `RCPA_ADDR_KEY:      rd_d = {24'h00_0000, key_q};
          `RCPA_ADDR_GENERAL:  rd_d = gp_q;
          `RCPA_ADDR_TIMECODE: rd_d = {24'h00_0000, time_code_i};
          default:             rd_d = {8'h00, ident_i[23:0]};
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      key_q  <= `RCPA_KEY_RESET;
      gp_q   <= 32'h0000_0000;
      rv_q   <= 1'b0;
      rs_q   <= `RCPA_ST_OK;
      rd_q   <= 32'h0000_0000;
      lock_q <= 16'h0000;
    end else begin
      key_q  <= key_d;
      gp_q   <= gp_d;
      rv_q   <= rv_d;
      rs_q   <= rs_d;
      rd_q   <= rd_d;
      lock_q <= lock_d;
    end
  end

  assign reply_valid_o        = rv_q;
  assign reply_status_o       = rs_q;
  assign reply_rdata_o        = rd_q;
  assign security_match_key_o = key_q;
  assign tx_lock_o            = (lock_q >= LOCK_CYCLES[15:0]);

  // Cycle count kept apart from lock_q, so the lock check does not grade itself
  logic [15:0] chk_cnt_q, chk_cnt_d;

  always_comb begin
    chk_cnt_d = chk_cnt_q;
    if (chk_cnt_q != 16'hffff) begin
      chk_cnt_d = chk_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chk_cnt_q <= 16'h0000;
    end else begin
      chk_cnt_q <= chk_cnt_d;
    end
  end

  a_key_reset: assert property (
    @(posedge clk_i)
    !reset_n_i |=> key_q == `RCPA_KEY_RESET)
    else $error("Key not reset");

  a_key_rdzero: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    rv_q && rs_q == `RCPA_ST_OK && $past(cmd_addr_i) == `RCPA_ADDR_KEY
    |-> rd_q[31:8] == 24'h00_0000)
    else $error("Key upper bits not zero");

  a_nack_reply: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && !cmd_empty_i && !cmd_key_req_i
    && kind == rcpa_pkg::RCPA_REG_NONE
    |=> rv_q && rs_q == `RCPA_ST_NACK && $stable(key_q) && $stable(gp_q))
    else $error("Unknown address not refused");

  // A refused command must not leak stale read data into its reply
  a_err_nodata: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    rv_q && rs_q != `RCPA_ST_OK |-> rd_q == 32'h0000_0000)
    else $error("Data on refused reply");

  a_empty_drop: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !(cmd_valid_i && !cmd_empty_i) |=> !rv_q)
    else $error("Reply without command");

  a_cmd_reply: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && !cmd_empty_i |=> rv_q)
    else $error("Command without reply");

  a_ro_write: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && !cmd_empty_i && cmd_write_i && !cmd_key_req_i
    && kind == rcpa_pkg::RCPA_REG_RO
    |=> rs_q == `RCPA_ST_RDONLY)
    else $error("Read-only write not flagged");

  a_ro_keep: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && !cmd_empty_i && cmd_write_i
    && kind == rcpa_pkg::RCPA_REG_RO
    |=> $stable(key_q) && $stable(gp_q))
    else $error("Read-only write changed state");

  a_ready_reset: assert property (
    @(posedge clk_i)
    $rose(reset_n_i) |-> ready_o)
    else $error("Not ready after reset");

  a_key_bad: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && !cmd_empty_i && cmd_key_req_i && cmd_key_i != key_q
    |=> rs_q == `RCPA_ST_KEYBAD && $stable(key_q) && $stable(gp_q))
    else $error("Key mismatch accepted");

  a_key_write: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && !cmd_empty_i && cmd_write_i && !cmd_key_req_i
    && cmd_addr_i == `RCPA_ADDR_KEY
    |=> key_q == $past(cmd_wdata_i[7:0]))
    else $error("Key write lost");

  // Lock follows the independent count, so it can be neither early nor late
  a_lock_early: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tx_lock_o == (chk_cnt_q >= LOCK_CYCLES[15:0]))
    else $error("Lock at wrong time");

  c_read_ok: cover property (
    @(posedge clk_i) rv_q && rs_q == `RCPA_ST_OK);

  c_nack: cover property (
    @(posedge clk_i) rv_q && rs_q == `RCPA_ST_NACK);

  c_ro_write: cover property (
    @(posedge clk_i) rv_q && rs_q == `RCPA_ST_RDONLY);

  c_key_bad: cover property (
    @(posedge clk_i) rv_q && rs_q == `RCPA_ST_KEYBAD);

  c_locked: cover property (
    @(posedge clk_i) $rose(tx_lock_o));

endmodule : rcpa_config_port
`default_nettype wire

// [test/rcpa_remote_node.sv]
`timescale 1ns/1ps
`default_nettype none
module rcpa_remote_node (
  input  wire logic                   clk_i,
  input  wire logic                   rv_i,
  input  wire rcpa_pkg::rcpa_status_t rs_i,
  input  wire logic [31:0]            rd_i,
  output logic                        v_o,
  output logic                        e_o,
  output logic                        w_o,
  output logic                        kr_o,
  output logic [8:0]                  a_o,
  output logic [31:0]                 d_o,
  output logic [7:0]                  k_o
);
  initial {v_o, e_o, w_o, kr_o, a_o, d_o, k_o} = '0;
  // Commands only, replies sampled 1 ns after the take edge
  task automatic send(input logic w, input logic [8:0] a, input logic [31:0] d,
    input logic kr, input logic [7:0] k, input logic e,
    output logic v, output rcpa_pkg::rcpa_status_t s, output logic [31:0] r);
    @(posedge clk_i);
    {v_o, e_o, w_o, kr_o} <= {1'b1, e, w, kr};
    {a_o, d_o, k_o} <= {a, d, k};
    @(posedge clk_i);
    // Valid and empty drop to 0 and address, data and key flip so a stale value is never mistaken for a held one
    {v_o, e_o, a_o, d_o, k_o} <= {2'b00, ~a, ~d, ~k};
    #1;
    {v, s, r} = {rv_i, rs_i, rd_i};
  endtask : send
endmodule : rcpa_remote_node
`default_nettype wire

// [test/tb_router_config_port_access.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rcpa_defines.svh"
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module tb_router_config_port_access;
  logic                   clk_i = 1'b0;
  logic                   reset_n_i = 1'b0;
  logic                   v, e, w, kr, rdy, rv, lk;
  logic [8:0]             a;
  logic [31:0]            d, rd;
  logic [7:0]             k, key;
  rcpa_pkg::rcpa_status_t rs;
  int                     errors = 0;
  int                     checked = 0;
  localparam logic [31:0] ID = 32'h5a3c7e11; // Arbitrary value
  rcpa_config_port #(.LOCK_CYCLES(10)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(v), .cmd_empty_i(e), .cmd_write_i(w), .cmd_addr_i(a), .cmd_wdata_i(d),
    .cmd_key_req_i(kr), .cmd_key_i(k), .time_code_i(8'h3c), .ident_i(ID), .ready_o(rdy),
    .reply_valid_o(rv), .reply_status_o(rs), .reply_rdata_o(rd),
    .security_match_key_o(key), .tx_lock_o(lk));
  rcpa_remote_node node (.clk_i(clk_i), .rv_i(rv), .rs_i(rs), .rd_i(rd), .v_o(v), .e_o(e),
    .w_o(w), .kr_o(kr), .a_o(a), .d_o(d), .k_o(k));
  initial forever #10 clk_i = ~clk_i;
  task automatic complete_run;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic t(input logic wr, input logic [8:0] ad, input logic [31:0] wd,
    input logic q, input logic [7:0] ky, input logic em,
    input logic xv, input logic [1:0] xs, input logic [31:0] xr);
    logic gv;
    rcpa_pkg::rcpa_status_t gs;
    logic [31:0] gr;
    node.send(wr, ad, wd, q, ky, em, gv, gs, gr);
    `CHK(gv, xv)
    if (xv) begin `CHK(gs, xs) `CHK(gr, xr) end
  endtask : t
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK(rdy, 1'b1)
    `CHK(lk, 1'b0)
    t(0, 9'h109, 0, 0, 0, 0, 1, `RCPA_ST_OK, 32'h20);
    t(1, 9'h109, 32'hffffffa5, 0, 0, 0, 1, `RCPA_ST_OK, 0);
    t(0, 9'h109, 0, 0, 0, 0, 1, `RCPA_ST_OK, 32'ha5);
    t(1, 9'h109, 32'h11, 1, 8'h5a, 0, 1, `RCPA_ST_KEYBAD, 0);
    `CHK(key, 8'ha5)
    t(1, 9'h109, 32'h33, 1, 8'ha5, 0, 1, `RCPA_ST_OK, 0);
    `CHK(key, 8'h33)
    $display("key tests done");
    t(1, 9'h1ff, 32'h7, 0, 0, 0, 1, `RCPA_ST_NACK, 0);
    t(0, 9'h108, 0, 0, 0, 0, 1, `RCPA_ST_NACK, 0);
    t(1, 9'h109, 32'h44, 0, 0, 1, 0, 0, 0);
    t(1, 9'h105, 32'hffffffff, 0, 0, 0, 1, `RCPA_ST_RDONLY, 0);
    t(0, 9'h105, 0, 0, 0, 0, 1, `RCPA_ST_OK, {8'h00, ID[23:0]});
    t(0, 9'h104, 0, 0, 0, 0, 1, `RCPA_ST_OK, 32'h3c);
    t(0, 9'h109, 0, 0, 0, 0, 1, `RCPA_ST_OK, 32'h33);
    $display("access tests done");
    for (int i = 0; i < 20 && lk !== 1'b1; i++) @(posedge clk_i);
    `CHK(lk, 1'b1)
    $display("lock test done");
    complete_run();
  end
endmodule : tb_router_config_port_access
`default_nettype wire
